/* verilog/dtc_pkg.sv */
// Purpose: shared constants and types for the dual timer/counter
// Assumes: APB byte addresses, 32-bit data, one word per register
// Notes: register offsets and field positions used by dtc_top and the verif files
package dtc_pkg;
	// apb geometry
	localparam int DTC_ADDR_W = 8;
	localparam int DTC_DATA_W = 32;
	// register byte offsets
	localparam logic [7:0] DTC_OFS_CTRL = 8'h00;
	localparam logic [7:0] DTC_OFS_CLKCTRL = 8'h04;
	localparam logic [7:0] DTC_OFS_COUNT0 = 8'h08;
	localparam logic [7:0] DTC_OFS_COUNT1 = 8'h0C;
	localparam logic [7:0] DTC_OFS_STATUS = 8'h10;
	localparam logic [7:0] DTC_OFS_MASK = 8'h14;
	// control register fields
	localparam int DTC_CTRL_W = 8;
	localparam int DTC_RUN0_BIT = 0;
	localparam int DTC_RUN1_BIT = 1;
	localparam int DTC_SRC0_BIT = 2;
	localparam int DTC_SRC1_BIT = 3;
	localparam int DTC_MODE0_LSB = 4;
	localparam int DTC_MODE1_LSB = 6;
	localparam int DTC_MODE_W = 2;
	localparam logic [7:0] DTC_CTRL_RST = 8'h00;
	// clock control register fields
	localparam int DTC_PS_W = 4;
	localparam int DTC_PS0_LSB = 0;
	localparam int DTC_PS1_LSB = 4;
	localparam int DTC_CLKCTRL_W = 8;
	localparam logic [7:0] DTC_CLKCTRL_RST = 8'h00;
	// prescaler stage
	localparam int DTC_PRESC_W = 13;
	// count fields
	localparam int DTC_BYTE_W = 8;
	localparam int DTC_HIGH_LSB = 8;
	localparam int DTC_M0_LOW_W = 5;
	localparam int DTC_M0_W = 13;
	localparam int DTC_M1_W = 16;
	localparam logic [7:0] DTC_COUNT_RST = 8'h00;
	// status and mask fields
	localparam int DTC_STAT_W = 2;
	localparam int DTC_STAT_OVF0 = 0;
	localparam int DTC_STAT_OVF1 = 1;
	localparam logic [1:0] DTC_STAT_RST = 2'h0;
	// operating modes
	typedef enum logic [1:0] {
		MODE_13BIT,
		MODE_16BIT,
		MODE_RELOAD,
		MODE_SPLIT
	} dtc_mode_type;
endpackage

/* verilog/dtc_prescaler.sv */
// Purpose: shared free-running prescaler stage with power-of-two taps
// Assumes: one clock, synchronous active-high reset
// Notes: tick pulses once every 2**sel cycles, sel saturates at width
`timescale 1ns/10ps
module dtc_prescaler #(
	parameter int WIDTH = 13,
	parameter int SEL_W = 4
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset,
	// tap selects
	input wire logic [SEL_W-1:0] i_sel_zero,
	input wire logic [SEL_W-1:0] i_sel_one,
	// tick enables
	output logic o_tick_zero,
	output logic o_tick_one
);
	logic [WIDTH-1:0] count_ff;
	logic [WIDTH-1:0] mask_zero;
	logic [WIDTH-1:0] mask_one;

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			count_ff <= '0;
		end else begin
			count_ff <= count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// low sel bits all ones marks the tap
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			mask_zero[i] = (i < int'(i_sel_zero));
			mask_one[i] = (i < int'(i_sel_one));
		end
		o_tick_zero = ((count_ff & mask_zero) == mask_zero);
		o_tick_one = ((count_ff & mask_one) == mask_one);
	end
endmodule // dtc_prescaler

/* verilog/dtc_fall_detect.sv */
// Purpose: synchronise a count pin and flag its falling edges
// Assumes: pin is asynchronous to i_clock
// Notes: pulse one cycle after the low level is seen twice synchronised
`timescale 1ns/10ps
module dtc_fall_detect (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset,
	// pin
	input wire logic i_pin,
	// falling edge pulse
	output logic o_fall
);
	logic meta_ff;
	logic sync_ff;
	logic prev_ff;
	logic fall_ff;

	// two-flop synchroniser then edge sample
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
			prev_ff <= 1'b1;
			fall_ff <= 1'b0;
		end else begin
			meta_ff <= i_pin;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
			fall_ff <= prev_ff & ~sync_ff;
		end
	end

	assign o_fall = fall_ff;
endmodule // dtc_fall_detect

/* verilog/dtc_top.sv */
// Purpose: two timer/counters with four modes behind an APB slave
// Assumes: 100 MHz i_clock, synchronous active-high i_reset
// Notes: count pins are synchronised before use; one wait state per access
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/10ps
module dtc_top
	import dtc_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [dtc_pkg::DTC_ADDR_W-1:0] i_paddr,
	input wire logic [dtc_pkg::DTC_DATA_W-1:0] i_pwdata,
	output logic [dtc_pkg::DTC_DATA_W-1:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// count pins
	input wire logic i_count_input_zero,
	input wire logic i_count_input_one,
	// interrupt
	output logic o_irq
);
	import dtc_pkg::*;

	// registers
	logic [DTC_CTRL_W-1:0] ctrl_ff;
	logic [DTC_CLKCTRL_W-1:0] timer_clock_control_reg_ff;
	logic [DTC_BYTE_W-1:0] low_count_byte_zero_ff;
	logic [DTC_BYTE_W-1:0] high_count_byte_zero_ff;
	logic [DTC_BYTE_W-1:0] low_count_byte_one_ff;
	logic [DTC_BYTE_W-1:0] high_count_byte_one_ff;
	logic [DTC_STAT_W-1:0] status_ff;
	logic [DTC_STAT_W-1:0] mask_ff;
	logic [DTC_DATA_W-1:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic irq_ff;

	// next values
	logic [DTC_BYTE_W-1:0] nxt_low0;
	logic [DTC_BYTE_W-1:0] nxt_high0;
	logic [DTC_BYTE_W-1:0] nxt_low1;
	logic [DTC_BYTE_W-1:0] nxt_high1;
	logic [DTC_DATA_W-1:0] nxt_prdata;
	logic nxt_pslverr;

	// internal
	logic access;
	logic wr_en;
	logic wr_ctrl;
	logic wr_clkctrl;
	logic wr_cnt0;
	logic wr_cnt1;
	logic wr_status;
	logic wr_mask;
	logic presc_tick0;
	logic presc_tick1;
	logic fall0;
	logic fall1;
	logic inc0;
	logic inc1;
	logic inc_split_high;
	logic ovf0;
	logic ovf1;
	logic ovf_split_high;
	logic [DTC_STAT_W-1:0] set_flags;
	logic [DTC_M0_W-1:0] sum13_0;
	logic [DTC_M0_W-1:0] sum13_1;
	logic [DTC_M1_W-1:0] sum16_0;
	logic [DTC_M1_W-1:0] sum16_1;
	dtc_mode_type mode0;
	dtc_mode_type mode1;

	// control field decode
	assign mode0 = dtc_mode_type'(ctrl_ff[DTC_MODE0_LSB +: DTC_MODE_W]);
	assign mode1 = dtc_mode_type'(ctrl_ff[DTC_MODE1_LSB +: DTC_MODE_W]);

	// shared prescaler stage
	dtc_prescaler #(
		.WIDTH(DTC_PRESC_W),
		.SEL_W(DTC_PS_W)
	) u_prescaler (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_sel_zero(timer_clock_control_reg_ff[DTC_PS0_LSB +: DTC_PS_W]),
		.i_sel_one(timer_clock_control_reg_ff[DTC_PS1_LSB +: DTC_PS_W]),
		.o_tick_zero(presc_tick0),
		.o_tick_one(presc_tick1)
	);

	// count pin edge detectors
	dtc_fall_detect u_fall_zero (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_pin(i_count_input_zero),
		.o_fall(fall0)
	);

	dtc_fall_detect u_fall_one (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_pin(i_count_input_one),
		.o_fall(fall1)
	);

	// source select per channel
	always_comb begin
		if (ctrl_ff[DTC_SRC0_BIT]) begin
			inc0 = ctrl_ff[DTC_RUN0_BIT] & fall0;
		end else begin
			inc0 = ctrl_ff[DTC_RUN0_BIT] & presc_tick0;
		end
		if (ctrl_ff[DTC_SRC1_BIT]) begin
			inc1 = ctrl_ff[DTC_RUN1_BIT] & fall1;
		end else begin
			inc1 = ctrl_ff[DTC_RUN1_BIT] & presc_tick1;
		end
		// split high byte is a pure timer gated by channel one run
		inc_split_high = ctrl_ff[DTC_RUN1_BIT] & presc_tick0;
	end

	// apb decode
	assign access = i_psel & i_penable;
	assign wr_en = access & i_pwrite & pready_ff;
	assign wr_ctrl = wr_en & (i_paddr == DTC_OFS_CTRL);
	assign wr_clkctrl = wr_en & (i_paddr == DTC_OFS_CLKCTRL);
	assign wr_cnt0 = wr_en & (i_paddr == DTC_OFS_COUNT0);
	assign wr_cnt1 = wr_en & (i_paddr == DTC_OFS_COUNT1);
	assign wr_status = wr_en & (i_paddr == DTC_OFS_STATUS);
	assign wr_mask = wr_en & (i_paddr == DTC_OFS_MASK);

	// channel zero counting
	always_comb begin
		nxt_low0 = low_count_byte_zero_ff;
		nxt_high0 = high_count_byte_zero_ff;
		ovf0 = 1'b0;
		ovf_split_high = 1'b0;
		sum13_0 = {high_count_byte_zero_ff, low_count_byte_zero_ff[DTC_M0_LOW_W-1:0]} +
			{{(DTC_M0_W-1){1'b0}}, 1'b1};
		sum16_0 = {high_count_byte_zero_ff, low_count_byte_zero_ff} +
			{{(DTC_M1_W-1){1'b0}}, 1'b1};
		if (wr_cnt0) begin
			nxt_low0 = i_pwdata[DTC_BYTE_W-1:0];
			nxt_high0 = i_pwdata[DTC_HIGH_LSB +: DTC_BYTE_W];
		end else begin
			case (mode0)
				MODE_13BIT: begin
					if (inc0) begin
						nxt_low0[DTC_M0_LOW_W-1:0] = sum13_0[DTC_M0_LOW_W-1:0];
						nxt_high0 = sum13_0[DTC_M0_W-1:DTC_M0_LOW_W];
						ovf0 = &{high_count_byte_zero_ff,
							low_count_byte_zero_ff[DTC_M0_LOW_W-1:0]};
					end
				end
				MODE_16BIT: begin
					if (inc0) begin
						{nxt_high0, nxt_low0} = sum16_0;
						ovf0 = &{high_count_byte_zero_ff, low_count_byte_zero_ff};
					end
				end
				MODE_RELOAD: begin
					if (inc0) begin
						if (&low_count_byte_zero_ff) begin
							nxt_low0 = high_count_byte_zero_ff;
							ovf0 = 1'b1;
						end else begin
							nxt_low0 = low_count_byte_zero_ff + 8'h01;
						end
					end
				end
				MODE_SPLIT: begin
					if (inc0) begin
						nxt_low0 = low_count_byte_zero_ff + 8'h01;
						ovf0 = &low_count_byte_zero_ff;
					end
					if (inc_split_high) begin
						nxt_high0 = high_count_byte_zero_ff + 8'h01;
						ovf_split_high = &high_count_byte_zero_ff;
					end
				end
				default: begin
					nxt_low0 = low_count_byte_zero_ff;
				end
			endcase
		end
	end

	// channel one counting, same modes, halted in split mode
	always_comb begin
		nxt_low1 = low_count_byte_one_ff;
		nxt_high1 = high_count_byte_one_ff;
		ovf1 = 1'b0;
		sum13_1 = {high_count_byte_one_ff, low_count_byte_one_ff[DTC_M0_LOW_W-1:0]} +
			{{(DTC_M0_W-1){1'b0}}, 1'b1};
		sum16_1 = {high_count_byte_one_ff, low_count_byte_one_ff} +
			{{(DTC_M1_W-1){1'b0}}, 1'b1};
		if (wr_cnt1) begin
			nxt_low1 = i_pwdata[DTC_BYTE_W-1:0];
			nxt_high1 = i_pwdata[DTC_HIGH_LSB +: DTC_BYTE_W];
		end else begin
			case (mode1)
				MODE_13BIT: begin
					if (inc1) begin
						nxt_low1[DTC_M0_LOW_W-1:0] = sum13_1[DTC_M0_LOW_W-1:0];
						nxt_high1 = sum13_1[DTC_M0_W-1:DTC_M0_LOW_W];
						ovf1 = &{high_count_byte_one_ff,
							low_count_byte_one_ff[DTC_M0_LOW_W-1:0]};
					end
				end
				MODE_16BIT: begin
					if (inc1) begin
						{nxt_high1, nxt_low1} = sum16_1;
						ovf1 = &{high_count_byte_one_ff, low_count_byte_one_ff};
					end
				end
				MODE_RELOAD: begin
					if (inc1) begin
						if (&low_count_byte_one_ff) begin
							nxt_low1 = high_count_byte_one_ff;
							ovf1 = 1'b1;
						end else begin
							nxt_low1 = low_count_byte_one_ff + 8'h01;
						end
					end
				end
				MODE_SPLIT: begin
					nxt_low1 = low_count_byte_one_ff;
				end
				default: begin
					nxt_low1 = low_count_byte_one_ff;
				end
			endcase
		end
	end

	// flag sources; split mode hands channel one's flag to the high byte
	always_comb begin
		set_flags = '0;
		set_flags[DTC_STAT_OVF0] = ovf0;
		if (mode0 == MODE_SPLIT) begin
			set_flags[DTC_STAT_OVF1] = ovf_split_high;
		end else begin
			set_flags[DTC_STAT_OVF1] = ovf1;
		end
	end

	// count registers
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			low_count_byte_zero_ff <= DTC_COUNT_RST;
			high_count_byte_zero_ff <= DTC_COUNT_RST;
			low_count_byte_one_ff <= DTC_COUNT_RST;
			high_count_byte_one_ff <= DTC_COUNT_RST;
		end else begin
			low_count_byte_zero_ff <= nxt_low0;
			high_count_byte_zero_ff <= nxt_high0;
			low_count_byte_one_ff <= nxt_low1;
			high_count_byte_one_ff <= nxt_high1;
		end
	end

	// control registers
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			ctrl_ff <= DTC_CTRL_RST;
			timer_clock_control_reg_ff <= DTC_CLKCTRL_RST;
			mask_ff <= DTC_STAT_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_ff <= i_pwdata[DTC_CTRL_W-1:0];
			end
			if (wr_clkctrl) begin
				timer_clock_control_reg_ff <= i_pwdata[DTC_CLKCTRL_W-1:0];
			end
			if (wr_mask) begin
				mask_ff <= i_pwdata[DTC_STAT_W-1:0];
			end
		end
	end

	// sticky flags, write one to clear, set wins
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			status_ff <= DTC_STAT_RST;
		end else if (wr_status) begin
			status_ff <= (status_ff & ~i_pwdata[DTC_STAT_W-1:0]) | set_flags;
		end else begin
			status_ff <= status_ff | set_flags;
		end
	end

	// interrupt level
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(status_ff & mask_ff);
		end
	end

	// read mux
	always_comb begin
		nxt_prdata = '0;
		nxt_pslverr = 1'b0;
		case (i_paddr)
			DTC_OFS_CTRL: begin
				nxt_prdata[DTC_CTRL_W-1:0] = ctrl_ff;
			end
			DTC_OFS_CLKCTRL: begin
				nxt_prdata[DTC_CLKCTRL_W-1:0] = timer_clock_control_reg_ff;
			end
			DTC_OFS_COUNT0: begin
				nxt_prdata[DTC_M1_W-1:0] = {high_count_byte_zero_ff, low_count_byte_zero_ff};
			end
			DTC_OFS_COUNT1: begin
				nxt_prdata[DTC_M1_W-1:0] = {high_count_byte_one_ff, low_count_byte_one_ff};
			end
			DTC_OFS_STATUS: begin
				nxt_prdata[DTC_STAT_W-1:0] = status_ff;
			end
			DTC_OFS_MASK: begin
				nxt_prdata[DTC_STAT_W-1:0] = mask_ff;
			end
			default: begin
				nxt_pslverr = 1'b1;
			end
		endcase
	end

	// apb answer, one wait state
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end else begin
			pready_ff <= access & ~pready_ff;
			if (access & ~pready_ff) begin
				pslverr_ff <= nxt_pslverr;
				prdata_ff <= i_pwrite ? '0 : nxt_prdata;
			end else begin
				pslverr_ff <= 1'b0;
				prdata_ff <= '0;
			end
		end
	end

	assign o_prdata = prdata_ff;
	assign o_pready = pready_ff;
	assign o_pslverr = pslverr_ff;
	assign o_irq = irq_ff;
endmodule // dtc_top

/* verif/dtc_sva.sv */
// Purpose: port checker for the dual timer/counter
// Assumes: one clock, synchronous active-high reset
// Notes: bound to dtc_top from the testbench file
`timescale 1ns/10ps
module dtc_sva
	import dtc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_count_input_zero,
	input wire logic i_count_input_one,
	input wire logic o_irq
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);
	logic mapped;
	logic acc_wr;
	assign mapped = (i_paddr[1:0] == 2'h0) && (i_paddr <= DTC_OFS_MASK);
	assign acc_wr = i_psel && i_penable && o_pready && i_pwrite;
	sequence setup_s;
		i_psel && !i_penable;
	endsequence
	sequence answer_s;
		!o_pready ##1 o_pready;
	endsequence
	wait_state_a: assert property (setup_s |=> answer_s)
		else $error("answer not after one wait state");
	ready_pulse_a: assert property (o_pready |=> !o_pready)
		else $error("ready longer than one cycle");
	ready_access_a: assert property (o_pready |-> i_psel && i_penable)
		else $error("ready outside access phase");
	decode_err_a: assert property (o_pready |-> o_pslverr == !mapped)
		else $error("error response wrong for address");
	err_only_a: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
		else $error("read data not zero while idle");
	irq_sticky_a: assert property (o_irq && !acc_wr && !$past(acc_wr) |=> o_irq)
		else $error("interrupt dropped without a write");
	irq_mask_a: assert property (acc_wr && i_paddr == DTC_OFS_MASK
		&& i_pwdata[1:0] == 2'h0 |-> ##[1:2] !o_irq)
		else $error("interrupt stays with mask cleared");
endmodule // dtc_sva

/* verif/dtc_pin_model.sv */
// Purpose: external source driving both count pins
// Assumes: pins idle high, pulled up
// Notes: low level held two clocks, high level three between pulses
`timescale 1ns/10ps
module dtc_pin_model (
	// clock
	input wire logic i_clock,
	// count pins
	output logic o_pin_zero,
	output logic o_pin_one
);
	initial begin
		o_pin_zero = 1'h1;
		o_pin_one = 1'h1;
	end
	// n falling edges on one pin, then settle
	task automatic pulse(input int ch, input int n);
		repeat (n) begin
			@(posedge i_clock);
			if (ch == 0) o_pin_zero <= 1'h0; else o_pin_one <= 1'h0;
			repeat (2) @(posedge i_clock);
			if (ch == 0) o_pin_zero <= 1'h1; else o_pin_one <= 1'h1;
			repeat (2) @(posedge i_clock);
		end
		repeat (8) @(posedge i_clock);
	endtask
endmodule // dtc_pin_model

/* verif/testbench.sv */
// Purpose: self-checking bench for the dual timer/counter
// Assumes: APB master tasks, pin model as the far side
// Notes: timer counts checked within windows of 38 to 43 and 9 to 12 ticks
`timescale 1ns/10ps
module testbench;
	import dtc_pkg::*;
	logic i_clock = 1'h0;
	logic i_reset = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, err, pin0, pin1, irq;
	int num_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #5 i_clock = ~i_clock;
	dtc_pin_model pins (.i_clock(i_clock), .o_pin_zero(pin0), .o_pin_one(pin1));
	dtc_top DUT (.i_clock(i_clock), .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_count_input_zero(pin0),
		.i_count_input_one(pin1), .o_irq(irq));
	task automatic end_of_test();
		if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clock);
		penable <= 1'h1;
		@(posedge i_clock);
		while (pready !== 1'h1) begin
			@(posedge i_clock);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge i_clock);
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(nm, rd, e);
	endtask
	initial begin
		repeat (8) @(posedge i_clock);
		i_reset <= 1'h0;
		@(posedge i_clock);
		for (int i = 0; i < 6; i++) rchk("reset_value", 8'(4 * i), 32'h0);
		apb(1'h0, 8'h18, 32'h0);
		chk("unmapped_rd_err", {31'h0, err}, 32'h1);
		apb(1'h1, 8'h1C, 32'hFF);
		chk("unmapped_wr_err", {31'h0, err}, 32'h1);
		// mode 1 counter on pin zero
		apb(1'h1, DTC_OFS_COUNT0, 32'hFFFE);
		apb(1'h1, DTC_OFS_CTRL, 32'h15);
		pins.pulse(0, 3);
		rchk("m1_count0", DTC_OFS_COUNT0, 32'h1);
		rchk("ovf0", DTC_OFS_STATUS, 32'h1);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		// mode 0 counter on pin one
		apb(1'h1, DTC_OFS_CTRL, 32'h0A);
		apb(1'h1, DTC_OFS_COUNT1, 32'hFFFF);
		apb(1'h1, DTC_OFS_MASK, 32'h2);
		pins.pulse(1, 1);
		rchk("m0_count1", DTC_OFS_COUNT1, 32'hE0);
		rchk("ovf1", DTC_OFS_STATUS, 32'h3);
		chk("irq_set", {31'h0, irq}, 32'h1);
		apb(1'h1, DTC_OFS_STATUS, 32'h3);
		rchk("status_clr", DTC_OFS_STATUS, 32'h0);
		chk("irq_clr", {31'h0, irq}, 32'h0);
		// mode 2 reload on channel zero
		apb(1'h1, DTC_OFS_COUNT0, 32'h40FE);
		apb(1'h1, DTC_OFS_CTRL, 32'h25);
		pins.pulse(0, 3);
		rchk("m2_count0", DTC_OFS_COUNT0, 32'h4041);
		// mode 3 on channel zero, channel one mode 1
		apb(1'h1, DTC_OFS_CTRL, 32'h00);
		apb(1'h1, DTC_OFS_COUNT0, 32'hFF10);
		apb(1'h1, DTC_OFS_COUNT1, 32'h100);
		apb(1'h1, DTC_OFS_CTRL, 32'h7F);
		pins.pulse(0, 2);
		pins.pulse(1, 3);
		apb(1'h1, DTC_OFS_CTRL, 32'h00);
		apb(1'h0, DTC_OFS_COUNT0, 32'h0);
		chk("m3_low0", rd & 32'hFF, 32'h12);
		rchk("m3_count1", DTC_OFS_COUNT1, 32'h103);
		rchk("m3_split_flag", DTC_OFS_STATUS, 32'h3);
		// mode 2 reload on channel one
		apb(1'h1, DTC_OFS_COUNT1, 32'h80FF);
		apb(1'h1, DTC_OFS_CTRL, 32'h8A);
		pins.pulse(1, 2);
		apb(1'h1, DTC_OFS_CTRL, 32'h00);
		rchk("m2_count1", DTC_OFS_COUNT1, 32'h8081);
		// timer mode, different prescale per channel
		apb(1'h1, DTC_OFS_COUNT0, 32'h0);
		apb(1'h1, DTC_OFS_COUNT1, 32'h0);
		apb(1'h1, DTC_OFS_CLKCTRL, 32'h42);
		apb(1'h1, DTC_OFS_CTRL, 32'h53);
		repeat (160) @(posedge i_clock);
		apb(1'h1, DTC_OFS_CTRL, 32'h00);
		apb(1'h0, DTC_OFS_COUNT0, 32'h0);
		chk("timer0_range", 32'(rd >= 38 && rd <= 43), 32'h1);
		apb(1'h0, DTC_OFS_COUNT1, 32'h0);
		chk("timer1_range", 32'(rd >= 9 && rd <= 12), 32'h1);
		apb(1'h1, DTC_OFS_MASK, 32'h0);
		repeat (2) @(posedge i_clock);
		chk("irq_mask_off", {31'h0, irq}, 32'h0);
		end_of_test();
	end
endmodule // testbench

bind dtc_top dtc_sva u_sva (.i_clock(i_clock), .i_reset(i_reset), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.i_count_input_zero(i_count_input_zero), .i_count_input_one(i_count_input_one),
	.o_irq(o_irq));
